// ===== shared/uaux_pkg.sv
// What this block does
// RULE_01: Special character detect only while enhanced bit 5.
// RULE_02: Matching character stored, special flag set.
// RULE_03: Compare only the selected word length bits.
// RULE_04: Character register bit 0 is received LSB.
// RULE_05: Half duplex: direction high after last stop.
// RULE_06: New transmit data drives direction low first.
// RULE_07: Zero bit gives 3/16 high pulse.
// RULE_08: Infrared enable; transmit idles low.
// RULE_09: Decoder idles low, pulse gives logic one.
// RULE_10: Feature bit 2 inverts infrared receive input.
// RULE_11: Sleep only when all channels are quiet.
// RULE_12: Oscillator stops while asleep.
// RULE_13: Start bit, transmit load, modem change wake.
// RULE_14: Sleep resumes once all conditions clear.
// RULE_15: Host reads modem status to clear changes.
// RULE_16: No sleep with interrupt pending; enable governs.
// RULE_17: Loopback routes transmit shift output to receiver.
// RULE_18: Loopback: mark, outputs deasserted, inputs ignored. With half duplex on, the direction output still goes low while transmitting.
// RULE_19: Far end keeps receive high during loopback.
// RULE_20: Upper interrupt enables need enhanced bit 4.
// RULE_21: Loopback ties modem outputs to modem inputs.
`default_nettype none
package uaux_pkg;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_EFR = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_LCR = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_FEATURE_CONTROL_REG = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_MCR = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_IER = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_XOFF2 = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_ISR = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_MSR = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_STAT = 6'h20;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int EFR_ENH_BIT = 4;
  localparam int EFR_SPECIAL_BIT = 5;
  localparam int FEATURE_CONTROL_REG_IRINV_BIT = 2;
  localparam int FEATURE_CONTROL_REG_HDX_BIT = 3;
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_OUT1_BIT = 2;
  localparam int MCR_OUT2_BIT = 3;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_IR_BIT = 6;
  localparam int IER_MS_BIT = 3;
  localparam int IER_SLEEP_BIT = 4;
  localparam int IER_XOFF_BIT = 5;
  localparam logic [7:0] IER_UPPER_MASK = 8'hF0;
  localparam int ISR_NOINT_BIT = 0;
  localparam int ISR_SPECIAL_BIT = 4;
  localparam int PIN_RX = 0;
  localparam int PIN_CTS = 1;
  localparam int PIN_DSR = 2;
  localparam int PIN_RI = 3;
  localparam int PIN_CD = 4;
  localparam int NUM_PINS = 5;
  localparam logic [NUM_PINS-1:0] PIN_SYNC_RESET = 5'h1F;
  localparam logic [4:0] TICKS_PER_BIT = 5'h10;
  localparam logic [4:0] IR_PULSE_TICKS = 5'h03;
  localparam logic [4:0] TICK_CNT_ZERO = 5'h00;
  typedef enum logic [0:0] {
    UAUX_AWAKE = 1'b0,
    UAUX_ASLEEP = 1'b1
  } uaux_sleep_state_t;
endpackage
`default_nettype wire

// ===== shared/uaux_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uaux_ir_if;
  logic tick;
  logic bitStart;
  logic txData;
  logic enable;
  logic invert;
  logic rxRaw;
  logic irTx;
  logic rxStream;
  modport ctrl(output tick, bitStart, txData, enable, invert, rxRaw, input irTx, rxStream);
  modport codec(input tick, bitStart, txData, enable, invert, rxRaw, output irTx, rxStream);
endinterface

interface uaux_sleep_if;
  logic allReady;
  logic wake;
  logic asleep;
  modport ctrl(output allReady, wake, input asleep);
  modport fsm(input allReady, wake, output asleep);
endinterface
`default_nettype wire

// ===== hw/uaux_irda_codec.sv
`timescale 1ns/1ps
`default_nettype none
module uaux_irda_codec (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the channel logic.
  uaux_ir_if.codec ir
);
  import uaux_pkg::*;

  logic [4:0] txCnt_q;
  logic [4:0] txCnt_d;
  logic [4:0] rxCnt_q;
  logic [4:0] rxCnt_d;
  logic irTx_q;
  logic rxStream_q;
  logic rxPrev_q;
  logic rxPol;
  logic pulseRise;

  // A zero bit loads the pulse length, counted down on 16x ticks.
  assign txCnt_d = ir.bitStart ? ((ir.enable && !ir.txData) ? IR_PULSE_TICKS : TICK_CNT_ZERO)
                 : (ir.tick && txCnt_q != TICK_CNT_ZERO) ? txCnt_q - 5'h01 : txCnt_q; // [RULE_07]
  assign rxPol = ir.rxRaw ^ ir.invert; // [RULE_10]
  // Reset treats the line as high, so a line already high at reset is not taken as light.
  assign pulseRise = ir.enable && rxPol && !rxPrev_q; // [RULE_09]
  assign rxCnt_d = pulseRise ? TICKS_PER_BIT
                 : (ir.tick && rxCnt_q != TICK_CNT_ZERO) ? rxCnt_q - 5'h01 : rxCnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txCnt_q <= TICK_CNT_ZERO;
      rxCnt_q <= TICK_CNT_ZERO;
      irTx_q <= 1'b0;
      rxStream_q <= 1'b0;
      rxPrev_q <= 1'b1;
    end else begin
      txCnt_q <= txCnt_d;
      rxCnt_q <= rxCnt_d;
      irTx_q <= txCnt_d != TICK_CNT_ZERO;
      rxStream_q <= rxCnt_d != TICK_CNT_ZERO; // [RULE_09]
      rxPrev_q <= rxPol;
    end
  end

  assign ir.irTx = irTx_q;
  assign ir.rxStream = rxStream_q;

  a_ir_zero_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ir.bitStart && ir.enable && !ir.txData |=> irTx_q) // [RULE_07]
    else $error("zero bit gave no infrared pulse");
  a_ir_one_dark: assert property (@(posedge clk) disable iff (!rst_n)
    ir.bitStart && ir.txData |=> !irTx_q) // [RULE_07]
    else $error("one bit gave an infrared pulse");
  a_ir_rx_one: assert property (@(posedge clk) disable iff (!rst_n)
    pulseRise |=> rxStream_q [*2]) // [RULE_09]
    else $error("light pulse not returned as one");
endmodule
`default_nettype wire

// ===== hw/uaux_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module uaux_sleep_ctrl (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Conditions and state.
  uaux_sleep_if.fsm slp
);
  import uaux_pkg::*;

  uaux_sleep_state_t state_q;
  uaux_sleep_state_t state_d;

  // Any wake event or lost condition leaves sleep; re-entry is automatic.
  always_comb begin
    state_d = state_q;
    case (state_q)
      UAUX_AWAKE: begin
        if (slp.allReady && !slp.wake) begin
          state_d = UAUX_ASLEEP; // [RULE_11] [RULE_14]
        end
      end
      UAUX_ASLEEP: begin
        if (slp.wake || !slp.allReady) begin
          state_d = UAUX_AWAKE; // [RULE_13] [RULE_16]
        end
      end
      default: begin
        state_d = UAUX_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= UAUX_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  assign slp.asleep = state_q == UAUX_ASLEEP;

  a_sleep_needs_ready: assert property (@(posedge clk) disable iff (!rst_n)
    !slp.allReady |=> !slp.asleep) // [RULE_16]
    else $error("asleep without all sleep conditions");
  a_wake_leaves: assert property (@(posedge clk) disable iff (!rst_n)
    slp.asleep && slp.wake |=> !slp.asleep) // [RULE_13]
    else $error("wake event did not end sleep");
  a_sleep_resumes: assert property (@(posedge clk) disable iff (!rst_n)
    slp.allReady && !slp.wake [*2] |-> slp.asleep) // [RULE_14]
    else $error("sleep not resumed when quiet");
endmodule
`default_nettype wire

// ===== hw/uaux_line_features.sv
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uaux_line_features #(
  parameter int NUM_CH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM register slave.
  input wire logic [uaux_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // UART core of this channel.
  input wire logic baud16Tick,
  input wire logic txBitStart,
  input wire logic coreTxd,
  input wire logic coreTxActive,
  input wire logic thrLoad,
  input wire logic rxCharValid,
  input wire logic [7:0] rxChar,
  input wire logic coreIntPending,
  output logic coreRxd,
  output logic rxCharStore,
  output logic [3:0] modemLevels,
  // Other channels of the chip.
  input wire logic [NUM_CH-2:0] peerIntPending,
  input wire logic [NUM_CH-2:0] peerSleepEn,
  input wire logic [NUM_CH-2:0] peerRxIdle,
  output logic chanIntPending,
  // Serial and modem pins.
  input wire logic rxPin,
  input wire logic ctsPin_n,
  input wire logic dsrPin_n,
  input wire logic riPin_n,
  input wire logic cdPin_n,
  output logic txPin,
  output logic rtsPin_n,
  output logic dtrPin_n,
  output logic transceiverDirectionOut,
  output logic auxOutputTwo_n,
  output logic oscEnable
);
  import uaux_pkg::*;

  uaux_ir_if irBus();
  uaux_sleep_if slpBus();

  logic [7:0] efr_q;
  logic [7:0] lcr_q;
  logic [7:0] feature_control_reg_q;
  logic [7:0] mcr_q;
  logic [7:0] ier_q;
  logic [7:0] xoff2_q;
  logic isrSpecial_q;
  logic isrSpecial_d;
  logic [3:0] msrDelta_q;
  logic [3:0] msrDelta_d;
  logic [3:0] modemPrev_q;
  logic ack_q;
  logic [31:0] readData_q;
  logic txPin_q;
  logic rts_q;
  logic dtr_q;
  logic dir_q;
  logic out2_q;
  logic coreRxd_q;
  logic rxPrev_q;

  // Pin synchronisers.
  logic [NUM_PINS-1:0] pinRaw;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] sync3_q;
  logic [NUM_PINS-1:0] pinFilt_q;

  assign pinRaw = {cdPin_n, riPin_n, dsrPin_n, ctsPin_n, rxPin};

  // A pin change is accepted once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_q[gi] <= PIN_SYNC_RESET[gi];
          sync2_q[gi] <= PIN_SYNC_RESET[gi];
          sync3_q[gi] <= PIN_SYNC_RESET[gi];
          pinFilt_q[gi] <= PIN_SYNC_RESET[gi];
        end else begin
          sync1_q[gi] <= pinRaw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            pinFilt_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Register bus decode.
  logic busReq;
  logic accept;
  logic wrAcc;
  logic rdAcc;
  logic wrLane0;
  logic [7:0] wrByte;
  logic [7:0] regRd;
  logic [7:0] ierEff;
  logic [7:0] isrRd;
  logic [7:0] statRd;

  assign busReq = avs_read || avs_write;
  assign accept = busReq && ack_q;
  assign wrAcc = accept && avs_write;
  assign rdAcc = accept && avs_read;
  assign wrLane0 = wrAcc && avs_byteenable[0];
  assign wrByte = avs_writedata[7:0];
  assign avs_waitrequest = busReq && !ack_q;

  logic wrEfr;
  logic wrLcr;
  logic wrFctr;
  logic wrMcr;
  logic wrIer;
  logic wrXoff2;
  logic wrIsr;
  logic rdMsr;

  assign wrEfr = wrLane0 && avs_address == OFF_EFR;
  assign wrLcr = wrLane0 && avs_address == OFF_LCR;
  assign wrFctr = wrLane0 && avs_address == OFF_FEATURE_CONTROL_REG;
  assign wrMcr = wrLane0 && avs_address == OFF_MCR;
  assign wrIer = wrLane0 && avs_address == OFF_IER;
  assign wrXoff2 = wrLane0 && avs_address == OFF_XOFF2;
  assign wrIsr = wrLane0 && avs_address == OFF_ISR;
  assign rdMsr = rdAcc && avs_address == OFF_MSR;

  // The upper enables are dead unless the enhanced functions are on.
  assign ierEff = efr_q[EFR_ENH_BIT] ? ier_q : (ier_q & ~IER_UPPER_MASK); // [RULE_20]

  // Mode decode.
  logic loopEn;
  logic irEn;
  logic hdxEn;
  logic sleepEnLocal;

  assign loopEn = mcr_q[MCR_LOOP_BIT];
  assign irEn = mcr_q[MCR_IR_BIT];
  assign hdxEn = feature_control_reg_q[FEATURE_CONTROL_REG_HDX_BIT];
  assign sleepEnLocal = ierEff[IER_SLEEP_BIT];

  // Special character detect, masked to the word length.
  logic [7:0] wordMask;
  logic specialHit;

  assign wordMask = 8'hFF >> (3'h3 - {1'b0, lcr_q[1:0]}); // [RULE_03]
  assign specialHit = efr_q[EFR_SPECIAL_BIT] && rxCharValid // [RULE_01]
                   && (((rxChar ^ xoff2_q) & wordMask) == 8'h00); // [RULE_04]
  // The matching character still goes to the receive FIFO.
  assign rxCharStore = rxCharValid; // [RULE_02]
  // A new match wins over a clear in the same cycle.
  assign isrSpecial_d = specialHit
                     || (isrSpecial_q && !(wrIsr && wrByte[ISR_SPECIAL_BIT])); // [RULE_02]

  // Modem inputs; loopback replaces the pins with the modem outputs.
  logic [3:0] modemPinLvl;
  logic [3:0] modemLoopLvl;
  logic [3:0] modemLvl;
  logic [3:0] modemChange;

  assign modemPinLvl = ~pinFilt_q[PIN_CD:PIN_CTS];
  assign modemLoopLvl = {mcr_q[MCR_OUT2_BIT], mcr_q[MCR_OUT1_BIT],
                         mcr_q[MCR_DTR_BIT], mcr_q[MCR_RTS_BIT]}; // [RULE_21]
  assign modemLvl = loopEn ? modemLoopLvl : modemPinLvl; // [RULE_18]
  assign modemChange = modemLvl ^ modemPrev_q;
  assign modemLevels = modemLvl;
  // A read clears only the changes that it returned.
  assign msrDelta_d = (msrDelta_q & ~(rdMsr ? readData_q[3:0] : 4'h0))
                    | modemChange; // [RULE_15]

  // Interrupt pending of this channel.
  logic localPend;

  assign localPend = coreIntPending
                  || (isrSpecial_q && ierEff[IER_XOFF_BIT])
                  || ((msrDelta_q != 4'h0) && ierEff[IER_MS_BIT]);
  assign chanIntPending = localPend;

  // Sleep conditions and wake events.
  logic rxFall;
  logic rxIdleAll;

  assign rxFall = rxPrev_q && !pinFilt_q[PIN_RX]; // [RULE_13]
  assign rxIdleAll = pinFilt_q[PIN_RX] && (&peerRxIdle);
  assign slpBus.allReady = !localPend && (peerIntPending == '0) // [RULE_16]
                        && sleepEnLocal && (&peerSleepEn)
                        && (msrDelta_q == 4'h0) && rxIdleAll
                        && !coreTxActive; // [RULE_11]
  assign slpBus.wake = rxFall || thrLoad || (modemPinLvl != modemPrev_q && !loopEn)
                    || (modemChange != 4'h0); // [RULE_13]
  assign oscEnable = !slpBus.asleep; // [RULE_12]

  uaux_sleep_ctrl u_sleep (
    .clk(clk),
    .rst_n(rst_n),
    .slp(slpBus)
  );

  // Infrared codec.
  assign irBus.tick = baud16Tick;
  assign irBus.bitStart = txBitStart;
  assign irBus.txData = coreTxd;
  assign irBus.enable = irEn; // [RULE_08]
  assign irBus.invert = feature_control_reg_q[FEATURE_CONTROL_REG_IRINV_BIT]; // [RULE_10]
  assign irBus.rxRaw = pinFilt_q[PIN_RX];

  uaux_irda_codec u_irda (
    .clk(clk),
    .rst_n(rst_n),
    .ir(irBus)
  );

  // Pin drive.
  logic txPin_d;
  logic dir_d;
  logic coreRxd_d;

  assign txPin_d = loopEn ? 1'b1 : (irEn ? irBus.irTx : coreTxd); // [RULE_08] [RULE_18]
  assign coreRxd_d = loopEn ? coreTxd // [RULE_17]
                   : (irEn ? irBus.rxStream : pinFilt_q[PIN_RX]); // [RULE_09]
  // In half duplex, direction goes low on a load, high once the last stop bit is out.
  assign dir_d = hdxEn ? !(thrLoad || coreTxActive) // [RULE_05] [RULE_06]
               : (loopEn || !mcr_q[MCR_OUT1_BIT]);

  // Read data.
  assign isrRd = {3'h0, isrSpecial_q, 3'h0, !localPend};
  assign statRd = {6'h00, dir_q, slpBus.asleep};
  assign regRd = (avs_address == OFF_EFR) ? efr_q
               : (avs_address == OFF_LCR) ? lcr_q
               : (avs_address == OFF_FEATURE_CONTROL_REG) ? feature_control_reg_q
               : (avs_address == OFF_MCR) ? mcr_q
               : (avs_address == OFF_IER) ? ier_q
               : (avs_address == OFF_XOFF2) ? xoff2_q
               : (avs_address == OFF_ISR) ? isrRd
               : (avs_address == OFF_MSR) ? {modemLvl, msrDelta_q}
               : (avs_address == OFF_STAT) ? statRd
               : 8'h00;

  // Control registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      efr_q <= REG_RESET;
      lcr_q <= REG_RESET;
      feature_control_reg_q <= REG_RESET;
      mcr_q <= REG_RESET;
      ier_q <= REG_RESET;
      xoff2_q <= REG_RESET;
    end else begin
      if (wrEfr) efr_q <= wrByte;
      if (wrLcr) lcr_q <= wrByte;
      if (wrFctr) feature_control_reg_q <= wrByte;
      if (wrMcr) mcr_q <= wrByte;
      if (wrIer) ier_q <= wrByte;
      if (wrXoff2) xoff2_q <= wrByte;
    end
  end

  // Bus handshake, status and pin flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      readData_q <= 32'h0000_0000;
      isrSpecial_q <= 1'b0;
      msrDelta_q <= 4'h0;
      modemPrev_q <= 4'h0;
      rxPrev_q <= 1'b1;
      txPin_q <= 1'b1;
      rts_q <= 1'b1;
      dtr_q <= 1'b1;
      dir_q <= 1'b1;
      out2_q <= 1'b1;
      coreRxd_q <= 1'b1;
    end else begin
      ack_q <= busReq && !ack_q;
      if (avs_read && !ack_q) readData_q <= {24'h00_0000, regRd};
      isrSpecial_q <= isrSpecial_d;
      msrDelta_q <= msrDelta_d;
      modemPrev_q <= modemLvl;
      rxPrev_q <= pinFilt_q[PIN_RX];
      txPin_q <= txPin_d;
      rts_q <= loopEn || !mcr_q[MCR_RTS_BIT]; // [RULE_18]
      dtr_q <= loopEn || !mcr_q[MCR_DTR_BIT]; // [RULE_18]
      dir_q <= dir_d;
      out2_q <= loopEn || !mcr_q[MCR_OUT2_BIT];
      coreRxd_q <= coreRxd_d;
    end
  end

  assign avs_readdata = readData_q;
  assign txPin = txPin_q;
  assign rtsPin_n = rts_q;
  assign dtrPin_n = dtr_q;
  assign transceiverDirectionOut = dir_q;
  assign auxOutputTwo_n = out2_q;
  assign coreRxd = coreRxd_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_special_gated: assert property (
    rxCharValid && !efr_q[EFR_SPECIAL_BIT] && !isrSpecial_q |=> !isrSpecial_q) // [RULE_01]
    else $error("special flag set while detect disabled");
  a_special_sets: assert property (specialHit |=> isrSpecial_q) // [RULE_02]
    else $error("special match did not set flag");
  a_word_five: assert property (rxCharValid && efr_q[EFR_SPECIAL_BIT] && lcr_q[1:0] == 2'h0
    && rxChar[4:0] == xoff2_q[4:0] |=> isrSpecial_q) // [RULE_03]
    else $error("five bit match missed");
  a_lsb_mismatch: assert property (rxCharValid && rxChar[0] != xoff2_q[0]
    && !isrSpecial_q |=> !isrSpecial_q) // [RULE_04]
    else $error("lsb mismatch still flagged");
  a_dir_low_load: assert property (hdxEn && thrLoad |=> !transceiverDirectionOut) // [RULE_06]
    else $error("direction not low on transmit load");
  a_dir_high_done: assert property (hdxEn && !thrLoad && !coreTxActive
    |=> transceiverDirectionOut) // [RULE_05]
    else $error("direction not high after transmit");
  a_ir_idle_low: assert property (irEn && !loopEn && !irBus.irTx |=> !txPin) // [RULE_08]
    else $error("infrared transmit not idling low");
  a_loop_mark: assert property (loopEn |=> txPin && rtsPin_n && dtrPin_n) // [RULE_18]
    else $error("loopback pins not at mark");
  a_loop_data: assert property (loopEn |=> coreRxd == $past(coreTxd)) // [RULE_17]
    else $error("loopback data not routed");
  a_loop_modem: assert property (loopEn |-> modemLvl[0] == mcr_q[MCR_RTS_BIT]) // [RULE_21]
    else $error("loopback modem tie wrong");
  a_no_sleep_pend: assert property (localPend |=> oscEnable) // [RULE_16]
    else $error("asleep with interrupt pending");
  a_bus_answer: assert property (busReq && !ack_q |=> !avs_waitrequest) // [RULE_15]
    else $error("bus answer late");

  c_special: cover property (specialHit);
  c_sleep: cover property (!oscEnable);
  c_loopback: cover property (loopEn && txBitStart);
  c_turnaround: cover property (hdxEn && $rose(transceiverDirectionOut));
endmodule
`default_nettype wire

// ===== verification/uaux_far_station.sv
`timescale 1ns/1ps
`default_nettype none
module uaux_far_station (
  // Clock.
  input wire logic clk,
  // Commands from the bench.
  input wire logic irMode,
  input wire logic zeroReq,
  input wire logic [3:0] modemDrive_n,
  // Line towards the block.
  output logic rxPin,
  output logic ctsPin_n,
  output logic dsrPin_n,
  output logic riPin_n,
  output logic cdPin_n
);
  logic [4:0] bitCnt_q = 5'h00;
  always @(posedge clk) begin
    if (zeroReq) begin
      bitCnt_q <= 5'h10;
    end else if (bitCnt_q != 5'h00) begin
      bitCnt_q <= bitCnt_q - 5'h01;
    end
  end
  // The wire line rests at mark, the optical link rests dark.
  assign rxPin = irMode ? (bitCnt_q > 5'h08) : (bitCnt_q == 5'h00);
  assign {cdPin_n, riPin_n, dsrPin_n, ctsPin_n} = modemDrive_n;
endmodule
`default_nettype wire

// ===== verification/uaux_line_features_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uaux_line_features_tb;
  import uaux_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic baud16Tick = 1'b1;
  logic txBitStart = 1'b0;
  logic coreTxd = 1'b1;
  logic coreTxActive = 1'b0;
  logic thrLoad = 1'b0;
  logic rxCharValid = 1'b0;
  logic [7:0] rxChar = 8'h00;
  logic coreIntPending = 1'b0;
  logic coreRxd, rxCharStore, chanIntPending;
  logic [3:0] modemLevels;
  logic [2:0] peerIntPending = 3'h0;
  logic [2:0] peerSleepEn = 3'h7;
  logic [2:0] peerRxIdle = 3'h7;
  logic rxPin, ctsPin_n, dsrPin_n, riPin_n, cdPin_n;
  logic txPin, rtsPin_n, dtrPin_n, transceiverDirectionOut, auxOutputTwo_n, oscEnable;
  logic farIr = 1'b0;
  logic farZero = 1'b0;
  logic [3:0] farModem_n = 4'hF;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  uaux_line_features #(.NUM_CH(4)) i_uaux_line_features (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .baud16Tick(baud16Tick), .txBitStart(txBitStart), .coreTxd(coreTxd),
    .coreTxActive(coreTxActive), .thrLoad(thrLoad), .rxCharValid(rxCharValid),
    .rxChar(rxChar), .coreIntPending(coreIntPending), .coreRxd(coreRxd),
    .rxCharStore(rxCharStore), .modemLevels(modemLevels), .peerIntPending(peerIntPending),
    .peerSleepEn(peerSleepEn), .peerRxIdle(peerRxIdle), .chanIntPending(chanIntPending),
    .rxPin(rxPin), .ctsPin_n(ctsPin_n), .dsrPin_n(dsrPin_n), .riPin_n(riPin_n),
    .cdPin_n(cdPin_n), .txPin(txPin), .rtsPin_n(rtsPin_n), .dtrPin_n(dtrPin_n),
    .transceiverDirectionOut(transceiverDirectionOut), .auxOutputTwo_n(auxOutputTwo_n),
    .oscEnable(oscEnable));
  uaux_far_station i_uaux_far_station (.clk(clk), .irMode(farIr), .zeroReq(farZero),
    .modemDrive_n(farModem_n), .rxPin(rxPin), .ctsPin_n(ctsPin_n), .dsrPin_n(dsrPin_n),
    .riPin_n(riPin_n), .cdPin_n(cdPin_n));

  always #12.5 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hung wait is cut short and counted as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic avWrite(input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic avRead(input logic [5:0] a, output logic [7:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input logic [7:0] c);
    rxChar <= c;
    rxCharValid <= 1'b1;
    @(posedge clk);
    chk(32'(rxCharStore), 32'h1);
    rxCharValid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitOsc(input logic exp);
    int n;
    n = 0;
    while (oscEnable !== exp && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(32'(oscEnable), 32'(exp));
  endtask

  task automatic t_reset();
    logic [5:0] offs [8];
    logic [7:0] d;
    offs = '{OFF_EFR, OFF_LCR, OFF_FEATURE_CONTROL_REG, OFF_MCR, OFF_IER, OFF_XOFF2, OFF_MSR, 6'h3C};
    avWrite(OFF_EFR, 8'hFF, 4'h0);
    avWrite(6'h3C, 8'hFF, 4'hF);
    foreach (offs[i]) begin
      avRead(offs[i], d);
      chk(32'(d), 32'(REG_RESET));
    end
    chk(32'({txPin, oscEnable}), 32'h3);
    $display("test reset done");
  endtask

  task automatic t_special();
    logic [7:0] d;
    avWrite(OFF_XOFF2, 8'h13, 4'hF);
    pulse(8'hF3);
    avRead(OFF_ISR, d);
    chk(32'(d[4]), 32'h0);
    avWrite(OFF_EFR, 8'h20, 4'hF);
    pulse(8'hF3);
    avRead(OFF_ISR, d);
    chk(32'(d[4]), 32'h1);
    avWrite(OFF_ISR, 8'h10, 4'hF);
    avWrite(OFF_LCR, 8'h03, 4'hF);
    pulse(8'hF3);
    pulse(8'h12);
    avRead(OFF_ISR, d);
    chk(32'(d[4]), 32'h0);
    pulse(8'h13);
    avRead(OFF_ISR, d);
    chk(32'(d[4]), 32'h1);
    avWrite(OFF_ISR, 8'h10, 4'hF);
    avWrite(OFF_EFR, 8'h00, 4'hF);
    $display("test special done");
  endtask

  task automatic t_hdx();
    avWrite(OFF_FEATURE_CONTROL_REG, 8'h08, 4'hF);
    thrLoad <= 1'b1;
    @(posedge clk);
    thrLoad <= 1'b0;
    coreTxActive <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(transceiverDirectionOut), 32'h0);
    coreTxActive <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(transceiverDirectionOut), 32'h1);
    avWrite(OFF_FEATURE_CONTROL_REG, 8'h00, 4'hF);
    $display("test half duplex done");
  endtask

  task automatic t_irda();
    int hi;
    avWrite(OFF_MCR, 8'h40, 4'hF);
    farIr <= 1'b1;
    repeat (30) @(posedge clk);
    chk(32'({txPin, coreRxd}), 32'h0);
    for (int b = 0; b < 2; b++) begin
      hi = 0;
      coreTxd <= 1'(b);
      txBitStart <= 1'b1;
      @(posedge clk);
      txBitStart <= 1'b0;
      repeat (16) begin
        @(posedge clk);
        if (txPin === 1'b1) hi++;
      end
      chk(32'(hi), (b == 0) ? 32'h3 : 32'h0);
    end
    farZero <= 1'b1;
    @(posedge clk);
    farZero <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(coreRxd), 32'h1);
    avWrite(OFF_FEATURE_CONTROL_REG, 8'h04, 4'hF);
    repeat (40) @(posedge clk);
    farZero <= 1'b1;
    @(posedge clk);
    farZero <= 1'b0;
    repeat (9) @(posedge clk);
    chk(32'(coreRxd), 32'h0);
    repeat (12) @(posedge clk);
    chk(32'(coreRxd), 32'h1);
    avWrite(OFF_FEATURE_CONTROL_REG, 8'h00, 4'hF);
    avWrite(OFF_MCR, 8'h00, 4'hF);
    farIr <= 1'b0;
    $display("test infrared done");
  endtask

  task automatic t_loop();
    avWrite(OFF_MCR, 8'h03, 4'hF);
    @(posedge clk);
    chk(32'({rtsPin_n, dtrPin_n}), 32'h0);
    avWrite(OFF_MCR, 8'h12, 4'hF);
    farModem_n <= 4'h0;
    repeat (8) @(posedge clk);
    chk(32'({txPin, rtsPin_n, dtrPin_n, auxOutputTwo_n}), 32'hF);
    chk(32'(modemLevels), 32'h1);
    coreTxd <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'({coreRxd, txPin}), 32'h1);
    coreTxd <= 1'b1;
    farModem_n <= 4'hF;
    repeat (3) @(posedge clk);
    chk(32'(coreRxd), 32'h1);
    avWrite(OFF_MCR, 8'h00, 4'hF);
    $display("test loopback done");
  endtask

  task automatic t_sleep();
    logic [7:0] d;
    avWrite(OFF_EFR, 8'h10, 4'hF);
    avWrite(OFF_IER, 8'h10, 4'hF);
    avRead(OFF_MSR, d);
    avRead(OFF_MSR, d);
    waitOsc(1'b0);
    farZero <= 1'b1;
    @(posedge clk);
    farZero <= 1'b0;
    waitOsc(1'b1);
    waitOsc(1'b0);
    coreIntPending <= 1'b1;
    thrLoad <= 1'b1;
    @(posedge clk);
    thrLoad <= 1'b0;
    waitOsc(1'b1);
    repeat (20) @(posedge clk);
    chk(32'(oscEnable), 32'h1);
    chk(32'(chanIntPending), 32'h1);
    coreIntPending <= 1'b0;
    waitOsc(1'b0);
    peerIntPending <= 3'h2;
    waitOsc(1'b1);
    peerIntPending <= 3'h0;
    waitOsc(1'b0);
    farModem_n <= 4'hE;
    waitOsc(1'b1);
    repeat (20) @(posedge clk);
    chk(32'(oscEnable), 32'h1);
    avRead(OFF_MSR, d);
    waitOsc(1'b0);
    avWrite(OFF_IER, 8'h00, 4'hF);
    farModem_n <= 4'hF;
    repeat (10) @(posedge clk);
    avRead(OFF_MSR, d);
    repeat (30) @(posedge clk);
    chk(32'(oscEnable), 32'h1);
    avWrite(OFF_EFR, 8'h00, 4'hF);
    avWrite(OFF_IER, 8'h10, 4'hF);
    repeat (30) @(posedge clk);
    chk(32'(oscEnable), 32'h1);
    $display("test sleep done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_special();
    t_hdx();
    t_irda();
    t_loop();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
